// *** hw/reload_timer_pkg.sv ***
// Shared constants for the reload/capture/baud timer: register map, control bits, reset values.
package reload_timer_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus geometry
    localparam int APB_ADDR_W = 12;            // Byte address width, index lives in bits above two
    localparam int INDEX_W = 10;               // Register index width
    localparam logic [1:0] WORD_ALIGN = 2'h0;  // Low address bits of an aligned word

    ////////////////////////////////////////////////////////////////////////////////
    // Register indices; byte address is four times the index
    localparam logic [9:0] CONTROL_INDEX = 10'h0c8;      // Timer control register
    localparam logic [9:0] RELOAD_LOW_INDEX = 10'h0ca;   // Capture/reload low byte
    localparam logic [9:0] RELOAD_HIGH_INDEX = 10'h0cb;  // Capture/reload high byte
    localparam logic [9:0] COUNT_LOW_INDEX = 10'h0cc;    // Count low byte
    localparam logic [9:0] COUNT_HIGH_INDEX = 10'h0cd;   // Count high byte
    localparam logic [9:0] CONTROL_BIT_INDEX = 10'h0ce;  // Single-bit access to the control register

    ////////////////////////////////////////////////////////////////////////////////
    // Control register bit positions
    localparam int OVERFLOW_FLAG_BIT = 7;
    localparam int EXTERNAL_EVENT_FLAG_BIT = 6;
    localparam int RX_CLOCK_SELECT_BIT = 5;
    localparam int TX_CLOCK_SELECT_BIT = 4;
    localparam int EXTERNAL_TRIGGER_ENABLE_BIT = 3;
    localparam int RUN_CONTROL_BIT = 2;
    localparam int COUNT_SOURCE_SELECT_BIT = 1;
    localparam int CAPTURE_MODE_SELECT_BIT = 0;

    // Single-bit access word: bit number in the low bits, new value above
    localparam int BIT_SEL_W = 3;
    localparam int BIT_VALUE_POS = 8;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values and counting constants
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] RELOAD_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    localparam logic [15:0] COUNT_STEP = 16'h0001;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    // Serial port modes that take their bit clock from a timer
    localparam logic [1:0] SERIAL_MODE_1 = 2'h1;
    localparam logic [1:0] SERIAL_MODE_3 = 2'h3;

endpackage

// *** hw/pin_edge_sync.sv ***
// Two-stage pin synchroniser with a falling-edge detector behind it.
`timescale 1ns/1ps
module pin_edge_sync #(
    parameter int STAGES = 2,              // Synchroniser depth, at least two
    parameter logic RESET_LEVEL = 1'b1     // Idle pin level, avoids a false edge after reset
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin_in,
    output logic pin_level,
    output logic fall_pulse
);

    logic [STAGES-1:0] sync_q; // Stage 0 is only read by stage 1
    logic prev_q;              // Previous synchronised level

    ////////////////////////////////////////////////////////////////////////////////
    // Shift the pin through the synchroniser
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_q <= {STAGES{RESET_LEVEL}};
        end else begin
            sync_q <= {sync_q[STAGES-2:0], pin_in};
        end
    end

    // Remember the last settled level for edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_q <= RESET_LEVEL;
        end else begin
            prev_q <= sync_q[STAGES-1];
        end
    end

    assign pin_level = sync_q[STAGES-1];
    // One-cycle pulse on a settled high-to-low change
    assign fall_pulse = prev_q & ~sync_q[STAGES-1];

endmodule

// *** hw/reload_timer.sv ***
// Sixteen-bit timer/counter with autoreload, capture and baud-clock modes behind an APB slave.
//
// The APB register port was decided locally.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Overflow flag set on rollover, not in baud mode
// - Trigger-caused capture or reload sets external flag
// - Receive clock select picks this timer's overflow
// - Transmit clock select picks this timer's overflow
// - Trigger pin honoured only when enabled, not baud
// - Run bit low stops the timer entirely
// - Source select picks count pin or clock
// - Capture select chooses capture versus autoreload
// - Baud mode forces autoreload, ignores capture select
// - Autoreload rollover sets flag, loads reload value
// - Enabled trigger edge also reloads and flags
// - Capture mode counts freely, flags each overflow
// - Capture copies count into reload bytes, flags
// - Baud mode: no overflow flag, trigger ignored so no external flag
// - Count and reload byte pairs are software accessible
// - Control resets to zero, bit access provided
module reload_timer
    import reload_timer_pkg::*;
#(
    parameter int SYNC_STAGES = 2     // Depth of the pin synchronisers
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic count_pin,         // External count input, asynchronous
    input wire logic trigger_pin,       // External trigger input, asynchronous
    input wire logic [1:0] serial_mode, // Serial port mode from the UART
    input wire logic timer1_overflow,   // Other timer's overflow pulse, same clock
    output logic timer_overflow,        // Registered overflow pulse
    output logic rx_baud_clock,         // Registered receive bit-clock pulse
    output logic tx_baud_clock,         // Registered transmit bit-clock pulse
    output logic overflow_flag,         // Sticky overflow flag level
    output logic external_event_flag    // Sticky external flag level
);

    ////////////////////////////////////////////////////////////////////////////////
    // State and next values
    logic [7:0] control_q;   // Timer control register
    logic [7:0] control_d;
    logic [15:0] count_q;    // Live count
    logic [15:0] count_d;
    logic [15:0] reload_q;   // Capture/reload value
    logic [15:0] reload_d;
    logic [31:0] prdata_q;   // Read data, captured in the setup cycle
    logic [31:0] prdata_d;
    logic timer_overflow_q;
    logic rx_baud_clock_q;
    logic tx_baud_clock_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic count_fall;        // Settled falling edge on the count pin
    logic trigger_fall;      // Settled falling edge on the trigger pin

    // Count pin: both edges settle through the same depth
    pin_edge_sync #(
        .STAGES(SYNC_STAGES),
        .RESET_LEVEL(1'b1)
    ) u_count_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in(count_pin),
        .pin_level(),
        .fall_pulse(count_fall)
    );

    // Trigger pin; a pin already low at reset gives one edge once it has settled
    pin_edge_sync #(
        .STAGES(SYNC_STAGES),
        .RESET_LEVEL(1'b1)
    ) u_trigger_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in(trigger_pin),
        .pin_level(),
        .fall_pulse(trigger_fall)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // APB decode
    logic [INDEX_W-1:0] index;   // Word index of the current address
    logic aligned;               // Low address bits are zero
    logic mapped;                // Address names a register
    logic setup_phase;
    logic access_phase;
    logic wr_en;                 // Write takes effect this edge
    logic control_wr;
    logic control_bit_wr;
    logic reload_low_wr;
    logic reload_high_wr;
    logic count_low_wr;
    logic count_high_wr;
    logic count_wr;              // Any software write to the count

    assign index = paddr[APB_ADDR_W-1:2];
    assign aligned = (paddr[1:0] == WORD_ALIGN);
    assign setup_phase = psel & ~penable;
    assign access_phase = psel & penable;

    // Only the six words answer; anything else is a slave error
    always_comb begin
        case (index)
            CONTROL_INDEX, CONTROL_BIT_INDEX, RELOAD_LOW_INDEX, RELOAD_HIGH_INDEX,
            COUNT_LOW_INDEX, COUNT_HIGH_INDEX: begin
                mapped = aligned;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // Data sits in byte lane zero, bar the bit-access value at bit 8; only strobe zero gates writes
    assign wr_en = access_phase & pwrite & mapped & pstrb[0];
    assign control_wr = wr_en & (index == CONTROL_INDEX);
    assign control_bit_wr = wr_en & (index == CONTROL_BIT_INDEX);
    assign reload_low_wr = wr_en & (index == RELOAD_LOW_INDEX);
    assign reload_high_wr = wr_en & (index == RELOAD_HIGH_INDEX);
    assign count_low_wr = wr_en & (index == COUNT_LOW_INDEX);
    assign count_high_wr = wr_en & (index == COUNT_HIGH_INDEX);
    assign count_wr = count_low_wr | count_high_wr;

    // Zero wait states; error only for unmapped words
    assign pready = 1'b1;
    assign pslverr = access_phase & ~mapped;

    ////////////////////////////////////////////////////////////////////////////////
    // Mode decode from the control register
    logic run;               // Timer enabled
    logic baud_mode;         // Either serial clock select set
    logic capture_mode;      // Capture select honoured
    logic trigger_enable;
    logic tick;              // One count step this cycle
    logic rollover;          // Count passes all ones to zero
    logic trigger_event;     // Qualified trigger edge
    logic capture_event;
    logic reload_event;
    logic overflow_flag_set;
    logic external_flag_set;
    logic serial_timed;      // Serial mode uses a timer bit clock

    assign run = control_q[RUN_CONTROL_BIT];
    assign baud_mode = control_q[RX_CLOCK_SELECT_BIT] | control_q[TX_CLOCK_SELECT_BIT];
    // Baud mode masks capture select and forces reload
    assign capture_mode = control_q[CAPTURE_MODE_SELECT_BIT] & ~baud_mode;
    assign trigger_enable = control_q[EXTERNAL_TRIGGER_ENABLE_BIT];

    // Count pin edges or every clock; nothing while stopped
    assign tick = run & (control_q[COUNT_SOURCE_SELECT_BIT] ? count_fall : 1'b1);
    assign rollover = tick & (count_q == COUNT_MAX);

    // Trigger ignored unless enabled and not clocking the UART; a stopped timer ignores it too
    assign trigger_event = run & trigger_enable & ~baud_mode & trigger_fall;
    assign capture_event = trigger_event & capture_mode;
    assign reload_event = (rollover & ~capture_mode) | (trigger_event & ~capture_mode);

    // No overflow flag while generating baud clocks
    assign overflow_flag_set = rollover & ~baud_mode;
    assign external_flag_set = trigger_event;

    assign serial_timed = (serial_mode == SERIAL_MODE_1) | (serial_mode == SERIAL_MODE_3);

    ////////////////////////////////////////////////////////////////////////////////
    // Control register: software write, then hardware sets on top
    always_comb begin
        control_d = control_q;
        if (control_wr) begin
            control_d = pwdata[7:0];
        end else if (control_bit_wr) begin
            // Single-bit write leaves the other bits alone
            control_d[pwdata[BIT_SEL_W-1:0]] = pwdata[BIT_VALUE_POS];
        end
        // Sets applied last so an event is never lost to a clear
        if (overflow_flag_set) begin
            control_d[OVERFLOW_FLAG_BIT] = 1'b1;
        end
        if (external_flag_set) begin
            control_d[EXTERNAL_EVENT_FLAG_BIT] = 1'b1;
        end
    end

    // Control register flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_q <= CONTROL_RESET;
        end else begin
            control_q <= control_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Count: reload or step, with software byte writes winning
    always_comb begin
        count_d = count_q;
        if (reload_event) begin
            count_d = reload_q;
        end else if (tick) begin
            count_d = count_q + COUNT_STEP;
        end
        // A software write is the newest intent, so it overrides the step
        if (count_low_wr) begin
            count_d[7:0] = pwdata[7:0];
        end
        if (count_high_wr) begin
            count_d[15:8] = pwdata[7:0];
        end
    end

    // Count flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= COUNT_RESET;
        end else begin
            count_q <= count_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Reload bytes: software preset, hardware capture wins
    always_comb begin
        reload_d = reload_q;
        if (reload_low_wr) begin
            reload_d[7:0] = pwdata[7:0];
        end
        if (reload_high_wr) begin
            reload_d[15:8] = pwdata[7:0];
        end
        // Capture keeps the measured edge time even against a write
        if (capture_event) begin
            reload_d = count_q;
        end
    end

    // Reload flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reload_q <= RELOAD_RESET;
        end else begin
            reload_q <= reload_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read data mux, sampled in the setup cycle so it is stable for access
    always_comb begin
        case (index)
            CONTROL_INDEX, CONTROL_BIT_INDEX: begin
                prdata_d = {24'h00_0000, control_q};
            end
            RELOAD_LOW_INDEX: begin
                prdata_d = {24'h00_0000, reload_q[7:0]};
            end
            RELOAD_HIGH_INDEX: begin
                prdata_d = {24'h00_0000, reload_q[15:8]};
            end
            COUNT_LOW_INDEX: begin
                prdata_d = {24'h00_0000, count_q[7:0]};
            end
            COUNT_HIGH_INDEX: begin
                prdata_d = {24'h00_0000, count_q[15:8]};
            end
            default: begin
                prdata_d = READ_ZERO;
            end
        endcase
        if (!aligned) begin
            prdata_d = READ_ZERO;
        end
    end

    // Read data flops; the count byte read is a snapshot of the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= READ_ZERO;
        end else if (setup_phase && !pwrite) begin
            prdata_q <= prdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Overflow and baud clock pulses to the UART
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_overflow_q <= 1'b0;
            rx_baud_clock_q <= 1'b0;
            tx_baud_clock_q <= 1'b0;
        end else begin
            timer_overflow_q <= rollover;
            // Only modes 1 and 3 take a timer bit clock
            rx_baud_clock_q <= serial_timed & (control_q[RX_CLOCK_SELECT_BIT] ? rollover : timer1_overflow);
            tx_baud_clock_q <= serial_timed & (control_q[TX_CLOCK_SELECT_BIT] ? rollover : timer1_overflow);
        end
    end

    assign prdata = prdata_q;
    assign timer_overflow = timer_overflow_q;
    assign rx_baud_clock = rx_baud_clock_q;
    assign tx_baud_clock = tx_baud_clock_q;
    assign overflow_flag = control_q[OVERFLOW_FLAG_BIT];
    assign external_event_flag = control_q[EXTERNAL_EVENT_FLAG_BIT];

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_ovf_flag_set;
        rollover && !baud_mode |=> overflow_flag;
    endproperty
    a_ovf_flag_set: assert property (p_ovf_flag_set) else $error("overflow flag not set on rollover");

    property p_ovf_flag_write_race;
        rollover && !baud_mode && control_wr && !pwdata[OVERFLOW_FLAG_BIT] |=> overflow_flag;
    endproperty
    a_ovf_flag_write_race: assert property (p_ovf_flag_write_race) else $error("software clear beat overflow");

    property p_no_ovf_flag_baud;
        baud_mode && !overflow_flag && !control_wr && !control_bit_wr |=> !overflow_flag;
    endproperty
    a_no_ovf_flag_baud: assert property (p_no_ovf_flag_baud) else $error("overflow flag set in baud mode");

    property p_ext_flag;
        trigger_event |=> external_event_flag;
    endproperty
    a_ext_flag: assert property (p_ext_flag) else $error("external flag not set on trigger");

    property p_trigger_ignored;
        (baud_mode || !trigger_enable) |-> !capture_event && !(reload_event && !rollover);
    endproperty
    a_trigger_ignored: assert property (p_trigger_ignored) else $error("trigger acted while disabled");

    property p_stopped;
        !run && !count_wr |=> $stable(count_q);
    endproperty
    a_stopped: assert property (p_stopped) else $error("count moved while stopped");

    property p_timer_step;
        run && !control_q[COUNT_SOURCE_SELECT_BIT] && !reload_event && !count_wr |=> count_q == 16'($past(count_q) + COUNT_STEP);
    endproperty
    a_timer_step: assert property (p_timer_step) else $error("timer did not step by one");

    property p_reload;
        reload_event && !count_wr |=> count_q == $past(reload_q);
    endproperty
    a_reload: assert property (p_reload) else $error("reload value not loaded");

    property p_baud_reload;
        baud_mode && rollover && !count_wr |=> count_q == $past(reload_q);
    endproperty
    a_baud_reload: assert property (p_baud_reload) else $error("baud mode did not reload");

    property p_capture_free_run;
        capture_mode && rollover && !count_wr |=> count_q == COUNT_RESET;
    endproperty
    a_capture_free_run: assert property (p_capture_free_run) else $error("capture mode did not wrap");

    property p_capture;
        capture_event |=> reload_q == $past(count_q) && external_event_flag;
    endproperty
    a_capture: assert property (p_capture) else $error("capture value wrong");

    property p_rx_clock;
        serial_mode == SERIAL_MODE_1 && control_q[RX_CLOCK_SELECT_BIT] && rollover |=> rx_baud_clock;
    endproperty
    a_rx_clock: assert property (p_rx_clock) else $error("receive clock missed overflow");

    property p_tx_clock;
        serial_mode == SERIAL_MODE_3 && !control_q[TX_CLOCK_SELECT_BIT] |=> tx_baud_clock == $past(timer1_overflow);
    endproperty
    a_tx_clock: assert property (p_tx_clock) else $error("transmit clock not from other timer");

endmodule

// *** sim/ext_pin_model.sv ***
// Model of the external count and trigger pins that feed the timer.
`timescale 1ns/1ps
module ext_pin_model (
    input wire logic pclk,
    output logic count_pin,
    output logic trigger_pin
);
    ////////////////////////////////////////////////////////////////////////////////
    // Pins rest high, so releasing reset gives no false edge
    initial begin
        count_pin = 1'b1;
        trigger_pin = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // n falling edges on one pin; four cycles low and high so sampling sees each one
    task automatic fall(input logic on_count, input int n);
        repeat (n) begin
            @(posedge pclk);
            if (on_count) begin
                count_pin <= 1'b0;
            end else begin
                trigger_pin <= 1'b0;
            end
            repeat (4) @(posedge pclk);
            count_pin <= 1'b1;
            trigger_pin <= 1'b1;
            repeat (4) @(posedge pclk);
        end
    endtask
endmodule

// *** sim/reload_timer_tb.sv ***
// Self-checking bench for the reload/capture/baud timer, driven over APB.
`timescale 1ns/1ps
module reload_timer_tb;
    import reload_timer_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, timer1_overflow;
    logic [APB_ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic [1:0] serial_mode;
    logic count_pin, trigger_pin, timer_overflow, rx_baud_clock, tx_baud_clock;
    logic overflow_flag, external_event_flag, err_seen;
    int fails = 0;
    int checks = 0;
    int rx_cnt = 0;
    int tx_cnt = 0;
    int ov_cnt = 0;
    int rx0, tx0, ov0;
    // Byte addresses of the registers
    localparam logic [11:0] A_CTL = {CONTROL_INDEX, WORD_ALIGN};
    localparam logic [11:0] A_RL = {RELOAD_LOW_INDEX, WORD_ALIGN};
    localparam logic [11:0] A_RH = {RELOAD_HIGH_INDEX, WORD_ALIGN};
    localparam logic [11:0] A_CL = {COUNT_LOW_INDEX, WORD_ALIGN};
    localparam logic [11:0] A_CH = {COUNT_HIGH_INDEX, WORD_ALIGN};
    localparam logic [11:0] A_BIT = {CONTROL_BIT_INDEX, WORD_ALIGN};

    reload_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .count_pin(count_pin), .trigger_pin(trigger_pin), .serial_mode(serial_mode),
        .timer1_overflow(timer1_overflow), .timer_overflow(timer_overflow), .rx_baud_clock(rx_baud_clock),
        .tx_baud_clock(tx_baud_clock), .overflow_flag(overflow_flag), .external_event_flag(external_event_flag));
    ext_pin_model ext (.pclk(pclk), .count_pin(count_pin), .trigger_pin(trigger_pin));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, baud pulse and overflow pulse counters
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        rx_cnt <= rx_cnt + (rx_baud_clock === 1'b1);
        tx_cnt <= tx_cnt + (tx_baud_clock === 1'b1);
        ov_cnt <= ov_cnt + (timer_overflow === 1'b1);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One APB transfer; held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdata = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic final_report();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog: the tests take well under 2000 cycles
    initial begin
        #200000;
        fails++;
        final_report();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Test sequence
    initial begin
        {presetn, psel, penable, pwrite, timer1_overflow} = 5'h00;
        {paddr, pwdata, serial_mode} = '0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values, then read-back and an unmapped place
        apb(0, A_CTL, 0); chk("control", 32'h00, rdata);
        apb(0, A_CH, 0); chk("count_high", 32'h00, rdata);
        apb(0, 12'h000, 0); chk("unmapped_err", 32'h1, {31'h0, err_seen});
        chk("unmapped_data", 32'h0, rdata);
        // Autoreload rollover, started through the bit-access word
        apb(1, A_CL, 32'hfe); apb(1, A_CH, 32'hff); apb(1, A_RL, 32'h34); apb(1, A_RH, 32'h12);
        apb(0, A_RH, 0); chk("reload_high", 32'h12, rdata);
        apb(1, A_BIT, 32'h102);
        repeat (20) @(posedge pclk);
        chk("ovf_flag", 32'h1, {31'h0, overflow_flag});
        apb(0, A_CTL, 0); chk("control_run", 32'h84, rdata);
        apb(0, A_CH, 0); chk("reloaded_high", 32'h12, rdata);
        // The flag register updates at the write edge, so look one edge later
        apb(1, A_CTL, 32'h00); @(posedge pclk);
        chk("ovf_cleared", 32'h0, {31'h0, overflow_flag});
        apb(0, A_CL, 0); rx0 = rdata; repeat (5) @(posedge pclk);
        apb(0, A_CL, 0); chk("stopped", rx0, rdata);
        // Capture on a trigger fall
        apb(1, A_CH, 32'h56); apb(1, A_CL, 32'h00); apb(1, A_CTL, 32'h0d);
        ext.fall(0, 1);
        chk("ext_flag", 32'h1, {31'h0, external_event_flag});
        apb(1, A_CTL, 32'h00); apb(0, A_RH, 0); chk("captured_high", 32'h56, rdata);
        // Trigger ignored with the enable clear
        apb(1, A_CTL, 32'h05); ext.fall(0, 1);
        chk("ext_ignored", 32'h0, {31'h0, external_event_flag});
        // Enabled trigger in autoreload mode reloads the count
        apb(1, A_RH, 32'h9a); apb(1, A_CTL, 32'h0c); ext.fall(0, 1);
        chk("reload_ext", 32'h1, {31'h0, external_event_flag});
        apb(1, A_CTL, 32'h00); apb(0, A_CH, 0); chk("trig_reload_high", 32'h9a, rdata);
        // Baud mode: no overflow flag, trigger ignored, both clocks pulse; count starts near rollover
        apb(1, A_RL, 32'hf0); apb(1, A_RH, 32'hff); apb(1, A_CL, 32'hf0); apb(1, A_CH, 32'hff);
        serial_mode <= SERIAL_MODE_1;
        rx0 = rx_cnt; tx0 = tx_cnt; ov0 = ov_cnt;
        apb(1, A_CTL, 32'h3c); ext.fall(0, 1); repeat (40) @(posedge pclk);
        chk("baud_ovf", 32'h0, {31'h0, overflow_flag});
        chk("baud_ext", 32'h0, {31'h0, external_event_flag});
        chk("rx_pulses", 32'h1, {31'h0, rx_cnt > rx0});
        chk("tx_pulses", 32'h1, {31'h0, tx_cnt > tx0});
        chk("ovf_pulses", 32'h1, {31'h0, ov_cnt > ov0});
        // Other timer feeds the receive clock when selects are clear
        apb(1, A_CTL, 32'h00); repeat (3) @(posedge pclk); rx0 = rx_cnt; serial_mode <= SERIAL_MODE_3;
        @(posedge pclk); timer1_overflow <= 1'b1; @(posedge pclk); timer1_overflow <= 1'b0;
        repeat (3) @(posedge pclk); chk("rx_from_t1", rx0 + 1, rx_cnt);
        // Counting pin falls
        apb(1, A_CL, 32'h00); apb(1, A_CH, 32'h00); apb(1, A_CTL, 32'h06);
        ext.fall(1, 3);
        apb(1, A_CTL, 32'h00); apb(0, A_CL, 0); chk("pin_count", 32'h03, rdata);
        final_report();
    end
endmodule
